// ===== hw/ibs_pkg.sv
// Package with the register map, field positions and reset values of the bus status block.
package ibs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus geometry.
    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 5;
    localparam int BYTE_W  = 8;
    localparam int FLAGS_W = 5;
    localparam int IRQ_W   = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_RX_HOLD  = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_TX_HOLD  = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 5'h10;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus status register field positions.
    localparam int BIT_STOP_SEEN  = 4;
    localparam int BIT_START_SEEN = 3;
    localparam int BIT_DIR_READ   = 2;
    localparam int BIT_RX_FULL    = 1;
    localparam int BIT_TX_FULL    = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask field positions.
    localparam int IRQ_START   = 0;
    localparam int IRQ_STOP    = 1;
    localparam int IRQ_ADDR    = 2;
    localparam int IRQ_RX_FULL = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [FLAGS_W-1:0] RST_FLAGS    = 5'h00;
    localparam logic [IRQ_W-1:0]   RST_IRQ_STAT = 4'h0;
    localparam logic [IRQ_W-1:0]   RST_IRQ_MASK = 4'h0;
    localparam logic [BYTE_W-1:0]  RST_BYTE     = 8'h00;
    localparam logic [DATA_W-1:0]  RST_RDATA    = 32'h00000000;

endpackage : ibs_pkg

// ===== hw/ibs_status.sv
// Bus status flags of a two-wire serial controller with an Avalon-MM register slave.
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps

module ibs_status (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic [ibs_pkg::ADDR_W-1:0]  address,
    input  wire logic                        read,
    input  wire logic                        write,
    input  wire logic [ibs_pkg::DATA_W-1:0]  writedata,
    output logic      [ibs_pkg::DATA_W-1:0]  readdata,
    output logic                             waitrequest,
    output logic                             irq,
    input  wire logic                        scl_in,
    input  wire logic                        sda_in,
    input  wire logic                        addr_rcvd,
    input  wire logic                        addr_rw,
    input  wire logic                        rx_byte_valid,
    input  wire logic [ibs_pkg::BYTE_W-1:0]  rx_byte,
    input  wire logic                        tx_done,
    output logic      [ibs_pkg::BYTE_W-1:0]  transmit_holding_register,
    output logic                             transmit_full_flag
);
    import ibs_pkg::*;

    // Address match helper shared by the read, write and side-effect decoders.
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
        hit = (addr == off);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and bus condition detection.

    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       scl_q;
    logic       sda_q;
    logic       start_det;
    logic       stop_det;

    // Three flops per pin; only the second synchroniser stage and its delayed copy feed logic.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_q    <= scl_sync[1];
            sda_q    <= sda_sync[1];
        end
    end

    // Data falling while the clock is high is a Start; data rising is a Stop.
    always_comb begin
        start_det = scl_q && scl_sync[1] && sda_q && !sda_sync[1];
        stop_det  = scl_q && scl_sync[1] && !sda_q && sda_sync[1];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus access decode.

    logic rd_go;
    logic wr_go;

    // An access completes in the cycle where waitrequest is already low.
    always_comb begin
        rd_go = read && !waitrequest;
        wr_go = write && !waitrequest;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status flags and holding registers.

    logic              stop_seen;
    logic              start_seen;
    logic              dir_read;
    logic              receive_full_flag;
    logic [BYTE_W-1:0] receive_holding_register;
    logic              next_stop_seen;
    logic              next_start_seen;
    logic              next_dir_read;
    logic              next_rx_full;
    logic              next_tx_full;
    logic [BYTE_W-1:0] next_rx_hold;
    logic [BYTE_W-1:0] next_tx_hold;

    // Next flag values; hardware sets win over clears in the same cycle.
    always_comb begin
        next_stop_seen  = stop_seen;
        next_start_seen = start_seen;
        next_dir_read   = dir_read;
        next_rx_full    = receive_full_flag;
        next_tx_full    = transmit_full_flag;
        next_rx_hold    = receive_holding_register;
        next_tx_hold    = transmit_holding_register;
        if (stop_det) begin
            next_stop_seen  = 1'b1;
            next_start_seen = 1'b0;
        end else if (start_det) begin
            next_stop_seen  = 1'b0;
            next_start_seen = 1'b1;
        end
        if (addr_rcvd) begin
            next_dir_read = addr_rw;
        end
        if (rd_go && hit(address, OFF_RX_HOLD)) begin
            next_rx_full = 1'b0;
        end
        if (rx_byte_valid) begin
            next_rx_full = 1'b1;
            next_rx_hold = rx_byte;
        end
        if (tx_done) begin
            next_tx_full = 1'b0;
        end
        if (wr_go && hit(address, OFF_TX_HOLD)) begin
            next_tx_full = 1'b1;
            next_tx_hold = writedata[BYTE_W-1:0];
        end
    end

    // Register the flags and holding registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stop_seen                 <= RST_FLAGS[BIT_STOP_SEEN];
            start_seen                <= RST_FLAGS[BIT_START_SEEN];
            dir_read                  <= RST_FLAGS[BIT_DIR_READ];
            receive_full_flag         <= RST_FLAGS[BIT_RX_FULL];
            transmit_full_flag        <= RST_FLAGS[BIT_TX_FULL];
            receive_holding_register  <= RST_BYTE;
            transmit_holding_register <= RST_BYTE;
        end else begin
            stop_seen                 <= next_stop_seen;
            start_seen                <= next_start_seen;
            dir_read                  <= next_dir_read;
            receive_full_flag         <= next_rx_full;
            transmit_full_flag        <= next_tx_full;
            receive_holding_register  <= next_rx_hold;
            transmit_holding_register <= next_tx_hold;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and output.

    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_events;
    logic [IRQ_W-1:0] next_irq_stat;
    logic [IRQ_W-1:0] next_irq_mask;
    logic             next_irq;

    // Write-one-to-clear status; an event in the same cycle keeps its bit set.
    always_comb begin
        irq_events              = '0;
        irq_events[IRQ_START]   = start_det;
        irq_events[IRQ_STOP]    = stop_det;
        irq_events[IRQ_ADDR]    = addr_rcvd;
        irq_events[IRQ_RX_FULL] = rx_byte_valid;
        next_irq_stat           = irq_stat;
        next_irq_mask           = irq_mask;
        if (wr_go && hit(address, OFF_IRQ_STAT)) begin
            next_irq_stat = irq_stat & ~writedata[IRQ_W-1:0];
        end
        if (wr_go && hit(address, OFF_IRQ_MASK)) begin
            next_irq_mask = writedata[IRQ_W-1:0];
        end
        next_irq_stat = next_irq_stat | irq_events;
        next_irq      = |(next_irq_stat & next_irq_mask);
    end

    // Register interrupt state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat <= RST_IRQ_STAT;
            irq_mask <= RST_IRQ_MASK;
            irq      <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            irq      <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave handshake and read data.

    logic              next_waitrequest;
    logic [DATA_W-1:0] next_readdata;

    // Each access waits one cycle; read data is loaded as waitrequest drops.
    always_comb begin
        next_waitrequest = 1'b1;
        next_readdata    = readdata;
        if ((read || write) && waitrequest) begin
            next_waitrequest = 1'b0;
        end
        if (read && waitrequest) begin
            next_readdata = RST_RDATA;
            if (hit(address, OFF_STATUS)) begin
                next_readdata[BIT_STOP_SEEN]  = stop_seen;
                next_readdata[BIT_START_SEEN] = start_seen;
                next_readdata[BIT_DIR_READ]   = dir_read;
                next_readdata[BIT_RX_FULL]    = receive_full_flag;
                next_readdata[BIT_TX_FULL]    = transmit_full_flag;
            end else if (hit(address, OFF_RX_HOLD)) begin
                next_readdata[BYTE_W-1:0] = receive_holding_register;
            end else if (hit(address, OFF_TX_HOLD)) begin
                next_readdata[BYTE_W-1:0] = transmit_holding_register;
            end else if (hit(address, OFF_IRQ_STAT)) begin
                next_readdata[IRQ_W-1:0] = irq_stat;
            end else if (hit(address, OFF_IRQ_MASK)) begin
                next_readdata[IRQ_W-1:0] = irq_mask;
            end
        end
    end

    // Register the bus answer.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata    <= RST_RDATA;
        end else begin
            waitrequest <= next_waitrequest;
            readdata    <= next_readdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // A Stop sets the stop-seen flag and clears the start-seen flag.
    property p_stop_last;
        stop_det |=> stop_seen && !start_seen;
    endproperty
    a_stop_last: assert property (p_stop_last) else $error("stop flag wrong after Stop");

    // A Start sets the start-seen flag and clears the stop-seen flag.
    property p_start_last;
        start_det |=> start_seen && !stop_seen;
    endproperty
    a_start_last: assert property (p_start_last) else $error("start flag wrong");

    // Without a bus condition both condition flags keep their value.
    property p_cond_hold;
        !start_det && !stop_det |=> $stable({stop_seen, start_seen});
    endproperty
    a_cond_hold: assert property (p_cond_hold) else $error("condition flags moved");

    // The direction flag follows the address read/write bit.
    property p_dir;
        addr_rcvd |=> dir_read == $past(addr_rw);
    endproperty
    a_dir: assert property (p_dir) else $error("direction flag wrong");

    // A received byte sets the full flag and lands in the holding register.
    property p_rx_set;
        rx_byte_valid |=> receive_full_flag && receive_holding_register == $past(rx_byte);
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("receive full not set");

    // Reading the receive register empties it unless a byte arrives too.
    property p_rx_clr;
        rd_go && hit(address, OFF_RX_HOLD) && !rx_byte_valid |=> !receive_full_flag;
    endproperty
    a_rx_clr: assert property (p_rx_clr) else $error("receive full not cleared");

    // A loaded transmit register stays full until the engine reports done.
    property p_tx_hold;
        transmit_full_flag && !tx_done |=> transmit_full_flag;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("transmit full dropped");

    // A software load of the transmit register marks it full.
    property p_tx_set;
        wr_go && hit(address, OFF_TX_HOLD) |=> transmit_full_flag;
    endproperty
    a_tx_set: assert property (p_tx_set) else $error("transmit full not set");

    // Every request is answered on the next edge and then released.
    property p_answer;
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");

    c_start_stop: cover property (start_det ##[1:200] stop_det);
    c_rx_read: cover property (rx_byte_valid ##[1:20] (rd_go && hit(address, OFF_RX_HOLD)));
    c_irq: cover property (!irq ##1 irq);

endmodule : ibs_status

// ===== tb/ibs_bus_model.sv
// Behavioural model of the far bus party and of the shift engine strobes.
`timescale 1ns/1ps

module ibs_bus_model (
    input  wire logic       clk,
    output logic            scl_in,
    output logic            sda_in,
    output logic            addr_rcvd,
    output logic            addr_rw,
    output logic            rx_byte_valid,
    output logic [7:0]      rx_byte,
    output logic            tx_done
);
    ////////////////////////////////////////////////////////////////////////////////
    // Idle bus: both lines pulled up, strobes low.
    initial begin
        scl_in = 1'b1;
        sda_in = 1'b1;
        addr_rcvd = 1'b0;
        addr_rw = 1'b0;
        rx_byte_valid = 1'b0;
        rx_byte = 8'h00;
        tx_done = 1'b0;
    end

    // Makes a Start (or Repeated Start) when stop is 0, else a Stop, with lines held stable.
    task automatic bus_cond(input logic stop);
        @(posedge clk) scl_in <= 1'b0;
        repeat (3) @(posedge clk);
        sda_in <= stop ? 1'b0 : 1'b1;
        repeat (3) @(posedge clk);
        scl_in <= 1'b1;
        repeat (3) @(posedge clk);
        sda_in <= stop ? 1'b1 : 1'b0;
        repeat (8) @(posedge clk);
    endtask : bus_cond

    // Pulses one strobe for one cycle: 0 address byte, 1 received byte, 2 transmit consumed.
    task automatic strobe(input int kind, input logic [7:0] d);
        @(posedge clk);
        addr_rcvd <= (kind == 0);
        addr_rw <= d[0];
        rx_byte_valid <= (kind == 1);
        rx_byte <= d;
        tx_done <= (kind == 2);
        @(posedge clk);
        addr_rcvd <= 1'b0;
        rx_byte_valid <= 1'b0;
        addr_rw <= ~d[0];
        rx_byte <= ~d;
        tx_done <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : strobe
endmodule : ibs_bus_model

// ===== tb/ibs_status_tb.sv
// Self-checking testbench of the bus status block.
`timescale 1ns/1ps

module ibs_status_tb;
    import ibs_pkg::*;

    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic [ADDR_W-1:0]  address = '0;
    logic               read = 1'b0;
    logic               write = 1'b0;
    logic [DATA_W-1:0]  writedata = '0;
    logic [DATA_W-1:0]  readdata;
    logic               waitrequest;
    logic               irq;
    logic               scl_in, sda_in, addr_rcvd, addr_rw, rx_byte_valid, tx_done;
    logic [BYTE_W-1:0]  rx_byte;
    logic [BYTE_W-1:0]  transmit_holding_register;
    logic               transmit_full_flag;
    logic [DATA_W-1:0]  es;
    int                 miscompares = 0;
    int                 checked = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock of 25 ns period.
    always #12.5 clk = ~clk;

    ibs_status ibs_status_i (.clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .scl_in(scl_in), .sda_in(sda_in),
        .addr_rcvd(addr_rcvd), .addr_rw(addr_rw), .rx_byte_valid(rx_byte_valid),
        .rx_byte(rx_byte), .tx_done(tx_done),
        .transmit_holding_register(transmit_holding_register),
        .transmit_full_flag(transmit_full_flag));

    ibs_bus_model ibs_bus_model_i (.clk(clk), .scl_in(scl_in), .sda_in(sda_in),
        .addr_rcvd(addr_rcvd), .addr_rw(addr_rw), .rx_byte_valid(rx_byte_valid),
        .rx_byte(rx_byte), .tx_done(tx_done));

    ////////////////////////////////////////////////////////////////////////////////
    // Prints the verdict and ends the run.
    task automatic end_of_test;
        if (miscompares == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test

    // Compares a value with its expectation and counts both.
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One Avalon transfer, held until waitrequest is sampled low.
    task automatic av(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        read <= ~wr;
        write <= wr;
        writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 100);
        q = readdata;
        if (n >= 100) chk(32'h00000001, 32'h00000000);
        read <= 1'b0;
        write <= 1'b0;
    endtask : av

    // Reads a register and compares it.
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] q;
        av(1'b0, a, '0, q);
        chk(q, exp);
    endtask : rd

    // Writes a register.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] q;
        av(1'b1, a, d, q);
    endtask : wr

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog that cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_of_test();
    end

    // Main sequence of tests.
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        es = '0;
        rd(OFF_STATUS, 32'h00000000);
        rd(OFF_IRQ_STAT, 32'h00000000);
        rd(OFF_IRQ_MASK, 32'h00000000);
        rd(5'h14, 32'h00000000);
        wr(OFF_STATUS, 32'hFFFFFFFF);
        rd(OFF_STATUS, 32'h00000000);
        wr(OFF_IRQ_MASK, 32'h0000000F);
        rd(OFF_IRQ_MASK, 32'h0000000F);
        ibs_bus_model_i.bus_cond(1'b0);
        es[BIT_START_SEEN] = 1'b1;
        rd(OFF_STATUS, es);
        chk(DATA_W'(irq), 32'h00000001);
        rd(OFF_IRQ_STAT, 32'h00000001);
        wr(OFF_IRQ_STAT, 32'h00000001);
        repeat (2) @(posedge clk);
        chk(DATA_W'(irq), 32'h00000000);
        ibs_bus_model_i.strobe(0, 8'h01);
        es[BIT_DIR_READ] = 1'b1;
        rd(OFF_STATUS, es);
        ibs_bus_model_i.bus_cond(1'b0);
        rd(OFF_STATUS, es);
        ibs_bus_model_i.strobe(0, 8'h00);
        es[BIT_DIR_READ] = 1'b0;
        rd(OFF_STATUS, es);
        ibs_bus_model_i.bus_cond(1'b1);
        es[BIT_START_SEEN] = 1'b0;
        es[BIT_STOP_SEEN] = 1'b1;
        rd(OFF_STATUS, es);
        ibs_bus_model_i.strobe(1, 8'hA5);
        es[BIT_RX_FULL] = 1'b1;
        rd(OFF_STATUS, es);
        rd(OFF_RX_HOLD, 32'h000000A5);
        es[BIT_RX_FULL] = 1'b0;
        rd(OFF_STATUS, es);
        wr(OFF_TX_HOLD, 32'h0000003C);
        es[BIT_TX_FULL] = 1'b1;
        rd(OFF_STATUS, es);
        chk(DATA_W'(transmit_full_flag), 32'h00000001);
        chk(DATA_W'(transmit_holding_register), 32'h0000003C);
        rd(OFF_TX_HOLD, 32'h0000003C);
        ibs_bus_model_i.strobe(2, 8'h00);
        es[BIT_TX_FULL] = 1'b0;
        rd(OFF_STATUS, es);
        ibs_bus_model_i.bus_cond(1'b0);
        es[BIT_START_SEEN] = 1'b1;
        es[BIT_STOP_SEEN] = 1'b0;
        rd(OFF_STATUS, es);
        rd(OFF_IRQ_STAT, 32'h0000000F);
        wr(OFF_IRQ_MASK, 32'h00000000);
        repeat (2) @(posedge clk);
        chk(DATA_W'(irq), 32'h00000000);
        wr(OFF_IRQ_STAT, 32'h0000000F);
        rd(OFF_IRQ_STAT, 32'h00000000);
        end_of_test();
    end
endmodule : ibs_status_tb
